//--- include/spit_defines.svh
// register map, field positions, reset values and timing counts
`ifndef SPIT_DEFINES_SVH
`define SPIT_DEFINES_SVH

`define SPIT_IDX_STEP_COUNT 8'h81
`define SPIT_IDX_WAIT_PERIOD 8'h83
`define SPIT_IDX_STEP_SIZE_LO 8'hca
`define SPIT_IDX_STEP_SIZE_HI 8'hcb
`define SPIT_IDX_COMMAND 8'hfa
`define SPIT_IDX_ENABLE 8'h80
`define SPIT_IDX_CONFIG 8'h70
`define SPIT_IDX_STATUS_SIX 8'ha7
`define SPIT_IDX_RUN_STATUS 8'h90

`define SPIT_RST_STEP_COUNT 8'h00
`define SPIT_RST_WAIT_PERIOD 8'h00
`define SPIT_RST_STEP_SIZE 16'h03e7
`define SPIT_RST_COMMAND 3'h0
`define SPIT_RST_ENABLE 8'h00
`define SPIT_RST_CONFIG 2'h0

`define SPIT_CMD_SLEEP_EXIT 0
`define SPIT_CMD_BUF_CLEAR 1
`define SPIT_CMD_AUTOZERO 2
`define SPIT_EN_POWER_ON 0
`define SPIT_EN_SPECTRAL 1
`define SPIT_EN_WAIT 3
`define SPIT_ST6_WAIT_SHORT 2

`define SPIT_CLK_PERIOD_PS 4000
`define SPIT_TICK_PS 2780000
`define SPIT_TICK_CYCLES (`SPIT_TICK_PS / `SPIT_CLK_PERIOD_PS)
`define SPIT_WAIT_UNIT_TICKS 1000
`define SPIT_AUTOZERO_TICKS 64

`endif

//--- include/spit_pkg.sv
// types shared by the integration timing block
`default_nettype none
package spit_pkg;
	typedef enum logic [1:0] {
		SPIT_IDLE = 2'b00,
		SPIT_INTEG = 2'b01,
		SPIT_WAIT = 2'b11,
		SPIT_AZERO = 2'b10
	} spit_state_t;

	typedef enum logic [1:0] {
		SPIT_MODE_NORMAL = 2'b00,
		SPIT_MODE_START_SYNC = 2'b01,
		SPIT_MODE_RESERVED = 2'b10,
		SPIT_MODE_EDGE_SYNC = 2'b11
	} spit_mode_t;

	typedef enum logic [3:0] {
		SPIT_R_NONE, SPIT_R_CNT, SPIT_R_WAIT, SPIT_R_SIZE_LO,
		SPIT_R_SIZE_HI, SPIT_R_CMD, SPIT_R_EN, SPIT_R_CFG,
		SPIT_R_ST6, SPIT_R_RUN
	} spit_reg_t;
endpackage
`default_nettype wire

//--- src/spit_tick_div.sv
// divider that makes the 2.78 us tick enable from the system clock
`default_nettype none
`include "spit_defines.svh"
module spit_tick_div (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	output logic tick
);
	localparam logic [9:0] LAST = 10'(`SPIT_TICK_CYCLES - 1);
	logic [9:0] cnt_q;
	logic tick_q;

	// the oscillator only runs while powered, so the divider restarts
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 10'h000;
			tick_q <= 1'b0;
		end else if (!run) begin
			cnt_q <= 10'h000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (cnt_q == LAST);
			cnt_q <= (cnt_q == LAST) ? 10'h000 : cnt_q + 10'h001;
		end
	end

	assign tick = tick_q;
endmodule
`default_nettype wire

//--- src/spit_pin_sync.sv
// three-stage synchroniser with agreement filter and rising edge pulse
`default_nettype none
module spit_pin_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin,
	output logic rise
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic lvl_q;
	logic rise_q;

	// s1 feeds only s2; a change counts once s2 and s3 agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			lvl_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				lvl_q <= s3_q;
			end
			rise_q <= (s2_q == s3_q) && s3_q && !lvl_q;
		end
	end

	assign rise = rise_q;
endmodule
`default_nettype wire

//--- src/spit_top.sv
// integration timing, wait timing and command logic with apb registers
//
// The implementer's own choice: the APB register port.
`default_nettype none
`include "spit_defines.svh"
//
// Behaviour
// - writing one to command bit 2 starts a manual autozero
// - command bit 1 clears buffer data, its flags and fill level
// - command bit 0 clears sleep-after-irq flag and resumes operation
// - modes 00/01 integrate (count+1)*(size+1) ticks of 2.78 us
// - step size resets to 999, a 2.78 ms step
// - full scale equals (count+1) times (size+1)
// - step count n in bits 7:0 gives n+1 steps, 1 to 256
// - step size n, low byte first, gives n+1 ticks per step
// - with wait enabled, measurements start on the wait period
// - wait setting n gives n+1 cycles of 2.78 ms between starts
// - wait shorter than integration sets the warning flag in 0xa7
// - mode 0 normal, 1 start-synced, 3 edge-synced, 2 reserved
module spit_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [9:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sync_pin,
	input wire logic sleep_req,
	output logic integrating,
	output logic measure_done,
	output logic autozero_active,
	output logic buffer_clear,
	output logic sleep_after_irq_active,
	output logic [24:0] full_scale
);
	import spit_pkg::*;

	logic [7:0] step_count_q;
	logic [7:0] wait_period_q;
	logic [15:0] step_size_q;
	logic [2:0] command_q;
	logic [7:0] enable_q;
	spit_mode_t mode_q;
	logic wait_too_short_flag_q;
	logic sleep_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	spit_state_t state_q;
	spit_state_t state_d;
	logic [15:0] sub_q;
	logic [7:0] steps_q;
	logic [9:0] wunit_q;
	logic [8:0] wcyc_q;
	logic wait_done_q;
	logic [6:0] az_q;
	logic integrating_q;
	logic measure_done_q;
	logic autozero_q;
	logic [24:0] full_scale_q;

	logic tick;
	logic sync_rise;
	logic power_on;
	logic can_run;
	logic start_ok;
	logic step_end;
	logic fin;
	logic restart;
	logic too_short;
	logic wr_en;
	spit_reg_t wr_sel;
	spit_reg_t rd_sel;

	// one decode serves both the read and the write path
	function automatic spit_reg_t reg_decode(input logic [9:0] a);
		spit_reg_t r;
		r = SPIT_R_NONE;
		if (a[1:0] == 2'b00) begin
			unique case (a[9:2])
				`SPIT_IDX_STEP_COUNT: r = SPIT_R_CNT;
				`SPIT_IDX_WAIT_PERIOD: r = SPIT_R_WAIT;
				`SPIT_IDX_STEP_SIZE_LO: r = SPIT_R_SIZE_LO;
				`SPIT_IDX_STEP_SIZE_HI: r = SPIT_R_SIZE_HI;
				`SPIT_IDX_COMMAND: r = SPIT_R_CMD;
				`SPIT_IDX_ENABLE: r = SPIT_R_EN;
				`SPIT_IDX_CONFIG: r = SPIT_R_CFG;
				`SPIT_IDX_STATUS_SIX: r = SPIT_R_ST6;
				`SPIT_IDX_RUN_STATUS: r = SPIT_R_RUN;
				default: r = SPIT_R_NONE;
			endcase
		end
		return r;
	endfunction

	assign power_on = enable_q[`SPIT_EN_POWER_ON];
	assign wr_sel = reg_decode(paddr);
	assign rd_sel = reg_decode(paddr);
	assign wr_en = psel && penable && pready_q && pwrite && pstrb[0]
		&& (wr_sel != SPIT_R_NONE);

	spit_tick_div u_tick (
		.clk(clk),
		.rst_n(rst_n),
		.run(power_on),
		.tick(tick)
	);

	spit_pin_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.pin(sync_pin),
		.rise(sync_rise)
	);

	// apb: zero wait states, answer registered in the setup cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= psel && !penable;
			pslverr_q <= psel && !penable && (rd_sel == SPIT_R_NONE);
			if (psel && !penable && !pwrite) begin
				unique case (rd_sel)
					SPIT_R_CNT: prdata_q <= {24'h0, step_count_q};
					SPIT_R_WAIT: prdata_q <= {24'h0, wait_period_q};
					SPIT_R_SIZE_LO: prdata_q <= {24'h0, step_size_q[7:0]};
					SPIT_R_SIZE_HI: prdata_q <= {24'h0, step_size_q[15:8]};
					SPIT_R_CMD: prdata_q <= {29'h0, command_q};
					SPIT_R_EN: prdata_q <= {24'h0, enable_q};
					SPIT_R_CFG: prdata_q <= {30'h0, mode_q};
					SPIT_R_ST6: prdata_q <= {29'h0,
						wait_too_short_flag_q, 2'h0};
					SPIT_R_RUN: prdata_q <= {26'h0, integrating_q,
						wait_done_q, sleep_q, 1'b0, state_q};
					SPIT_R_NONE: prdata_q <= 32'h0000_0000;
				endcase
			end else begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	// timing setup registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			step_count_q <= `SPIT_RST_STEP_COUNT;
			wait_period_q <= `SPIT_RST_WAIT_PERIOD;
			step_size_q <= `SPIT_RST_STEP_SIZE;
			enable_q <= `SPIT_RST_ENABLE;
			mode_q <= SPIT_MODE_NORMAL;
		end else if (wr_en) begin
			unique case (wr_sel)
				SPIT_R_CNT: step_count_q <= pwdata[7:0];
				SPIT_R_WAIT: wait_period_q <= pwdata[7:0];
				SPIT_R_SIZE_LO: step_size_q[7:0] <= pwdata[7:0];
				SPIT_R_SIZE_HI: step_size_q[15:8] <= pwdata[7:0];
				SPIT_R_EN: enable_q <= pwdata[7:0];
				SPIT_R_CFG: mode_q <= spit_mode_t'(pwdata[1:0]);
				default: begin
				end
			endcase
		end
	end

	// command bits live one cycle, then read back as zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			command_q <= `SPIT_RST_COMMAND;
		end else if (wr_en && wr_sel == SPIT_R_CMD) begin
			command_q <= pwdata[2:0];
		end else begin
			command_q <= 3'h0;
		end
	end

	// sleep flag: a new sleep request wins over a same-cycle exit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_q <= 1'b0;
		end else if (sleep_req) begin
			sleep_q <= 1'b1;
		end else if (command_q[`SPIT_CMD_SLEEP_EXIT]) begin
			sleep_q <= 1'b0;
		end
	end

	// warning flag is write-one-to-clear; a new event wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_too_short_flag_q <= 1'b0;
		end else if (too_short) begin
			wait_too_short_flag_q <= 1'b1;
		end else if (wr_en && wr_sel == SPIT_R_ST6
			&& pwdata[`SPIT_ST6_WAIT_SHORT]) begin
			wait_too_short_flag_q <= 1'b0;
		end
	end

	// edge-synced mode 3 never integrates here; reserved acts normal
	assign can_run = power_on && enable_q[`SPIT_EN_SPECTRAL] && !sleep_q
		&& (mode_q != SPIT_MODE_EDGE_SYNC);
	assign start_ok = (mode_q == SPIT_MODE_START_SYNC) ? sync_rise : 1'b1;
	assign step_end = tick && (sub_q == step_size_q);
	assign fin = (state_q == SPIT_INTEG) && step_end
		&& (steps_q == step_count_q);
	assign too_short = fin && enable_q[`SPIT_EN_WAIT] && wait_done_q;

	always_comb begin
		state_d = state_q;
		restart = 1'b0;
		unique case (state_q)
			SPIT_IDLE: begin
				if (command_q[`SPIT_CMD_AUTOZERO]) begin
					state_d = SPIT_AZERO;
				end else if (can_run && start_ok) begin
					state_d = SPIT_INTEG;
					restart = 1'b1;
				end
			end
			SPIT_INTEG: begin
				if (command_q[`SPIT_CMD_AUTOZERO]) begin
					state_d = SPIT_AZERO;
				end else if (!can_run) begin
					state_d = SPIT_IDLE;
				end else if (fin) begin
					if (enable_q[`SPIT_EN_WAIT] && !wait_done_q) begin
						state_d = SPIT_WAIT;
					end else if (mode_q == SPIT_MODE_START_SYNC) begin
						state_d = SPIT_IDLE;
					end else begin
						restart = 1'b1;
					end
				end
			end
			SPIT_WAIT: begin
				if (command_q[`SPIT_CMD_AUTOZERO]) begin
					state_d = SPIT_AZERO;
				end else if (!can_run) begin
					state_d = SPIT_IDLE;
				end else if (wait_done_q) begin
					if (mode_q == SPIT_MODE_START_SYNC) begin
						state_d = SPIT_IDLE;
					end else begin
						state_d = SPIT_INTEG;
						restart = 1'b1;
					end
				end
			end
			SPIT_AZERO: begin
				if (tick && az_q == 7'(`SPIT_AUTOZERO_TICKS - 1)) begin
					state_d = SPIT_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SPIT_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// step counters: size+1 ticks per step, count+1 steps
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sub_q <= 16'h0000;
			steps_q <= 8'h00;
		end else if (restart || state_q != SPIT_INTEG) begin
			sub_q <= 16'h0000;
			steps_q <= 8'h00;
		end else if (step_end) begin
			sub_q <= 16'h0000;
			steps_q <= steps_q + 8'h01;
		end else if (tick) begin
			sub_q <= sub_q + 16'h0001;
		end
	end

	// wait period runs from each start: wait_period+1 units of 2.78 ms
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wunit_q <= 10'h000;
			wcyc_q <= 9'h000;
			wait_done_q <= 1'b0;
		end else if (restart) begin
			wunit_q <= 10'h000;
			wcyc_q <= 9'h000;
			wait_done_q <= 1'b0;
		end else if (tick && !wait_done_q) begin
			if (wunit_q == 10'(`SPIT_WAIT_UNIT_TICKS - 1)) begin
				wunit_q <= 10'h000;
				wcyc_q <= wcyc_q + 9'h001;
				wait_done_q <= (wcyc_q == {1'b0, wait_period_q});
			end else begin
				wunit_q <= wunit_q + 10'h001;
			end
		end
	end

	// autozero duration counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			az_q <= 7'h00;
		end else if (state_q != SPIT_AZERO) begin
			az_q <= 7'h00;
		end else if (tick) begin
			az_q <= az_q + 7'h01;
		end
	end

	// full scale follows the settings; product fits 25 bits at most
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			full_scale_q <= 25'h0000000;
		end else begin
			full_scale_q <= (25'(step_count_q) + 25'h1)
				* (25'(step_size_q) + 25'h1);
		end
	end

	// status outputs registered so that every output is a flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			integrating_q <= 1'b0;
			measure_done_q <= 1'b0;
			autozero_q <= 1'b0;
		end else begin
			integrating_q <= (state_d == SPIT_INTEG);
			measure_done_q <= fin;
			// flop follows state_d so it rises with state_q, not later
			autozero_q <= (state_d == SPIT_AZERO);
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign integrating = integrating_q;
	assign measure_done = measure_done_q;
	assign autozero_active = autozero_q;
	assign buffer_clear = command_q[`SPIT_CMD_BUF_CLEAR];
	assign sleep_after_irq_active = sleep_q;
	assign full_scale = full_scale_q;
endmodule
`default_nettype wire

//--- verification/spit_top_asserts.sv
// port assertions for the integration timing block
`default_nettype none
`include "spit_defines.svh"
module spit_top_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [9:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sync_pin,
	input wire logic sleep_req,
	input wire logic integrating,
	input wire logic measure_done,
	input wire logic autozero_active,
	input wire logic buffer_clear,
	input wire logic sleep_after_irq_active,
	input wire logic [24:0] full_scale
);
	import spit_pkg::*;
	logic wr_cmd;
	assign wr_cmd = psel && penable && pready && pwrite && pstrb[0] &&
		paddr == {`SPIT_IDX_COMMAND, 2'b00};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	setup_ready_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	clear_cause_a: assert property (
		buffer_clear |-> $past(wr_cmd && pwdata[`SPIT_CMD_BUF_CLEAR]))
		else $error("buffer clear without command");
	clear_pulse_a: assert property (
		wr_cmd && pwdata[`SPIT_CMD_BUF_CLEAR] |=> buffer_clear ##1 !buffer_clear)
		else $error("buffer clear not a single pulse");
	sleep_exit_a: assert property (
		wr_cmd && pwdata[`SPIT_CMD_SLEEP_EXIT] ##1 !sleep_req
		|=> !sleep_after_irq_active)
		else $error("sleep flag not cleared");
	sleep_set_a: assert property (sleep_req |=> sleep_after_irq_active)
		else $error("sleep flag not set");
	autozero_go_a: assert property (
		wr_cmd && pwdata[`SPIT_CMD_AUTOZERO] |-> ##[1:3] autozero_active)
		else $error("autozero did not start");
	done_pulse_a: assert property (measure_done |=> !measure_done)
		else $error("done longer than one cycle");
	scale_hold_a: assert property (
		$past(rst_n, 2) && !$past(psel) && !$past(psel, 2)
		|-> $stable(full_scale))
		else $error("full scale moved without a write");
	done_seen_c: cover property (measure_done);
	clear_seen_c: cover property (buffer_clear);
	az_seen_c: cover property ($rose(autozero_active));
endmodule
bind spit_top spit_top_asserts u_chk (.clk, .rst_n, .paddr, .psel,
	.penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
	.sync_pin, .sleep_req, .integrating, .measure_done, .autozero_active,
	.buffer_clear, .sleep_after_irq_active, .full_scale);
`default_nettype wire

//--- verification/spit_top_bench.sv
// self-checking bench for the integration timing block
`default_nettype none
`include "spit_defines.svh"
module spit_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import spit_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, sync_pin, sleep_req;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic pready, pslverr, integrating, measure_done, er;
	logic autozero_active, buffer_clear, sleep_after_irq_active;
	logic [24:0] full_scale, fs;
	logic [7:0] c;
	logic [15:0] s;
	int n_fail, samples_checked, n;
	spit_top dut (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .sync_pin, .sleep_req,
		.integrating, .measure_done, .autozero_active, .buffer_clear,
		.sleep_after_irq_active, .full_scale);
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task report_and_stop;
		$display("checks=%0d fails=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// no wait-state count assumed: the loop only bounds a hang
	task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int k;
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) n_fail++;
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rdchk(input logic [7:0] idx, input logic [31:0] exp);
		apb(0, idx, 8'h0);
		chk(rd, exp);
	endtask
	task wait_done;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (measure_done !== 1'b1 && n < 10000);
	endtask
	initial begin
		#200000;
		n_fail++;
		report_and_stop;
	end
	initial begin
		rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
		pwdata = '0; pstrb = 4'hf; sync_pin = 0; sleep_req = 0;
		n_fail = 0; samples_checked = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1;
		repeat (2) @(negedge clk);
		chk(full_scale, 32'd1000);
		rdchk(`SPIT_IDX_STEP_COUNT, 32'h0);
		rdchk(`SPIT_IDX_WAIT_PERIOD, 32'h0);
		rdchk(`SPIT_IDX_STEP_SIZE_LO, 32'he7);
		rdchk(`SPIT_IDX_STEP_SIZE_HI, 32'h03);
		rdchk(`SPIT_IDX_COMMAND, 32'h0);
		apb(0, 8'h00, 8'h0);
		chk(er, 1);
		chk(rd, 0);
		for (int i = 0; i < 3; i++) begin
			c = (i == 0) ? 8'h03 : (i == 1) ? 8'hff : 8'h1d;
			s = (i == 0) ? 16'h0004 : (i == 1) ? 16'hfffe : 16'h0257;
			apb(1, `SPIT_IDX_STEP_COUNT, c);
			apb(1, `SPIT_IDX_STEP_SIZE_LO, s[7:0]);
			apb(1, `SPIT_IDX_STEP_SIZE_HI, s[15:8]);
			repeat (2) @(negedge clk);
			fs = (25'(c) + 25'd1) * (25'(s) + 25'd1);
			chk(full_scale, fs);
			rdchk(`SPIT_IDX_STEP_COUNT, c);
		end
		apb(1, `SPIT_IDX_COMMAND, 8'h02);
		@(negedge clk);
		chk(buffer_clear, 1);
		@(negedge clk);
		chk(buffer_clear, 0);
		rdchk(`SPIT_IDX_COMMAND, 32'h0);
		@(posedge clk);
		sleep_req <= 1;
		@(posedge clk);
		sleep_req <= 0;
		@(negedge clk);
		chk(sleep_after_irq_active, 1);
		apb(1, `SPIT_IDX_COMMAND, 8'h01);
		repeat (2) @(negedge clk);
		chk(sleep_after_irq_active, 0);
		apb(1, `SPIT_IDX_STEP_COUNT, 8'h00);
		apb(1, `SPIT_IDX_STEP_SIZE_LO, 8'h01);
		apb(1, `SPIT_IDX_STEP_SIZE_HI, 8'h00);
		apb(1, `SPIT_IDX_ENABLE, 8'h03);
		// the first done after a change may mix settings, so skip it
		for (int i = 0; i < 2; i++) begin
			wait_done;
			wait_done;
			chk(n, (2 * i + 1) * 2 * `SPIT_TICK_CYCLES);
			apb(1, `SPIT_IDX_STEP_COUNT, 8'h02);
		end
		// start-synced mode idles after a done until the pin rises
		apb(1, `SPIT_IDX_CONFIG, 8'h01);
		rdchk(`SPIT_IDX_CONFIG, 32'h01);
		wait_done;
		@(negedge clk);
		chk(integrating, 0);
		@(posedge clk);
		sync_pin <= 1;
		repeat (8) @(negedge clk);
		chk(integrating, 1);
		// a wait far longer than integration parks the sequencer in wait
		apb(1, `SPIT_IDX_CONFIG, 8'h00);
		apb(1, `SPIT_IDX_ENABLE, 8'h0b);
		wait_done;
		rdchk(`SPIT_IDX_RUN_STATUS, 32'h03);
		rdchk(`SPIT_IDX_STATUS_SIX, 32'h0);
		apb(1, `SPIT_IDX_ENABLE, 8'h01);
		apb(1, `SPIT_IDX_COMMAND, 8'h04);
		repeat (3) @(negedge clk);
		chk(autozero_active, 1);
		report_and_stop;
	end
endmodule
`default_nettype wire
